//--- vcb_consts.vh
// Constants shared by the receive-chain configuration register bank.
`ifndef VCB_CONSTS_VH
`define VCB_CONSTS_VH

// ****************************************************************
// Register indices and byte addresses (byte address = 4 x index)
// ****************************************************************
`define VCB_IDX_TERM 8'h34
`define VCB_IDX_POWER 8'h35
`define VCB_IDX_TBUF 8'h36
`define VCB_IDX_CHGAIN 8'h39
`define VCB_IDX_ATTEN 8'h3b
`define VCB_ADDR_TERM 12'h0d0
`define VCB_ADDR_POWER 12'h0d4
`define VCB_ADDR_TBUF 12'h0d8
`define VCB_ADDR_CHGAIN 12'h0e4
`define VCB_ADDR_ATTEN 12'h0ec

// ****************************************************************
// Reset values
// ****************************************************************
`define VCB_RST_REG 16'h0000

// ****************************************************************
// Field positions: input termination register
// ****************************************************************
`define VCB_TERM_RES_LSB 0
`define VCB_TERM_RES_MSB 4
`define VCB_TERM_INDIV_EN 5
`define VCB_TERM_PRESET_LSB 6
`define VCB_TERM_PRESET_MSB 7
`define VCB_TERM_ACT_EN 8
`define VCB_GLOBAL_GAIN_LSB 13
`define VCB_GLOBAL_GAIN_MSB 14
`define VCB_PERCH_EN 15

// ****************************************************************
// Field positions: power mode register
// ****************************************************************
`define VCB_PWR_LOW 10
`define VCB_PWR_MED 11
`define VCB_PWR_PDN_ATTGS 12
`define VCB_PWR_PDN_PRE 13
`define VCB_PWR_PARTIAL 14
`define VCB_PWR_FULL 15

// ****************************************************************
// Field positions: test buffer and attenuator registers
// ****************************************************************
`define VCB_TBUF_FB_LSB 0
`define VCB_TBUF_FB_MSB 4
`define VCB_ATT_CORNER_LSB 2
`define VCB_ATT_CORNER_MSB 3
`define VCB_ATT_STEPS_LSB 4
`define VCB_ATT_STEPS_MSB 6
`define VCB_ATT_DIG_EN 7
`define VCB_ATT_TBUF_PWR 8
`define VCB_ATT_TEST_ROUTE 9

// ****************************************************************
// Gain codes and preset termination resistor maps
// ****************************************************************
`define VCB_GAIN_18DB 2'h0
`define VCB_GAIN_24DB 2'h1
`define VCB_GAIN_12DB 2'h2
`define VCB_MAP24_50 5'h01
`define VCB_MAP24_100 5'h02
`define VCB_MAP24_200 5'h04
`define VCB_MAP24_400 5'h08
`define VCB_MAP18_50 5'h07
`define VCB_MAP18_100 5'h0e
`define VCB_MAP18_200 5'h1c
`define VCB_MAP18_400 5'h18
`define VCB_MAP12_50 5'h00
`define VCB_MAP12_100 5'h03
`define VCB_MAP12_200 5'h06
`define VCB_MAP12_400 5'h0c

`endif

//--- vcb_power_decode.v
// Power mode resolution for the receive chain.
`default_nettype none

module vcb_power_decode (
    // Power mode register contents
    input wire [15:0] powerReg,
    // Resolved power controls
    output wire mediumPowerMode,
    output wire lowPowerMode,
    output wire lowNoiseMode,
    output wire preampOff,
    output wire attenGainstageOff,
    output wire partialSleep,
    output wire fullSleep
);
`include "vcb_consts.vh"

    // Each power mode needs the other select clear; both set falls back to low noise.
    assign mediumPowerMode = powerReg[`VCB_PWR_MED] & ~powerReg[`VCB_PWR_LOW];
    assign lowPowerMode = powerReg[`VCB_PWR_LOW] & ~powerReg[`VCB_PWR_MED];
    assign lowNoiseMode = ~(mediumPowerMode | lowPowerMode);

    // Full sleep overrides partial sleep.
    assign fullSleep = powerReg[`VCB_PWR_FULL];
    assign partialSleep = powerReg[`VCB_PWR_PARTIAL] & ~powerReg[`VCB_PWR_FULL];

    // Individual stage power-downs, also forced by either sleep state.
    assign preampOff = powerReg[`VCB_PWR_PDN_PRE] | fullSleep | partialSleep;
    assign attenGainstageOff = powerReg[`VCB_PWR_PDN_ATTGS] | fullSleep | partialSleep;

endmodule // vcb_power_decode
`default_nettype wire

//--- vcb_term_decode.v
// Preamp gain selection and input termination resistor decoding.
`default_nettype none

module vcb_term_decode #(
    parameter CHANNELS = 8
) (
    // Register contents
    input wire [15:0] termReg,
    input wire [15:0] chanGainReg,
    // Decoded controls
    output wire [2*CHANNELS-1:0] chanPreampGain,
    output wire [4:0] terminationFeedback
);
`include "vcb_consts.vh"

    // Picks the resistor map for a preset impedance at a given preamp gain.
    function [4:0] presetMap;
        input [1:0] gain;
        input [1:0] preset;
        begin
            case (gain)
                `VCB_GAIN_24DB: begin
                    case (preset)
                        2'h0: presetMap = `VCB_MAP24_50;
                        2'h1: presetMap = `VCB_MAP24_100;
                        2'h2: presetMap = `VCB_MAP24_200;
                        default: presetMap = `VCB_MAP24_400;
                    endcase
                end
                `VCB_GAIN_12DB: begin
                    case (preset)
                        2'h0: presetMap = `VCB_MAP12_50;
                        2'h1: presetMap = `VCB_MAP12_100;
                        2'h2: presetMap = `VCB_MAP12_200;
                        default: presetMap = `VCB_MAP12_400;
                    endcase
                end
                default: begin
                    case (preset)
                        2'h0: presetMap = `VCB_MAP18_50;
                        2'h1: presetMap = `VCB_MAP18_100;
                        2'h2: presetMap = `VCB_MAP18_200;
                        default: presetMap = `VCB_MAP18_400;
                    endcase
                end
            endcase
        end
    endfunction

    wire [1:0] globalGain;
    wire perChanEn;
    wire [4:0] presetRes;

    assign globalGain = termReg[`VCB_GLOBAL_GAIN_MSB:`VCB_GLOBAL_GAIN_LSB];
    assign perChanEn = termReg[`VCB_PERCH_EN];

    // Each channel takes its own field when per-channel control is on, else the global one.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
            assign chanPreampGain[2*ch+1:2*ch] = perChanEn ?
                chanGainReg[2*ch+1:2*ch] : globalGain;
        end
    endgenerate

    // Preset decoding follows the global gain; 50 ohm at 12 dB is high impedance.
    assign presetRes = presetMap(globalGain,
        termReg[`VCB_TERM_PRESET_MSB:`VCB_TERM_PRESET_LSB]);

    // Individual resistor bits win when enabled; termination off selects none.
    assign terminationFeedback = ~termReg[`VCB_TERM_ACT_EN] ? 5'h00 :
        termReg[`VCB_TERM_INDIV_EN] ?
        termReg[`VCB_TERM_RES_MSB:`VCB_TERM_RES_LSB] : presetRes;

endmodule // vcb_term_decode
`default_nettype wire

//--- vcb_config_bank.v
// Configuration register bank of the eight-channel receive chain, APB slave.
//
// Function
// - Medium-power select sets medium-power mode when reduced-current select is clear.
// - Attenuator/gain-stage power-down bit powers down attenuator and gain stage.
// - Preamp power-down bit powers down only the preamplifier.
// - Partial sleep partially powers down preamp, attenuator and gain stage.
// - Full sleep powers all three down completely and overrides partial sleep.
// - Test-buffer feedback field enables parallel resistors, one per bit.
// - Test-buffer feedback applies only in gain-stage test mode.
// - Per-channel gain register holds eight two-bit preamp gain fields.
// - Two-bit offset-loop corner field selects the high-pass corner.
// - Digital attenuation N turns on N shunt switches, only when enabled.
// - Digital attenuator enable moves control from analog voltage to steps.
// - Test-buffer power bit: zero powers down, one is normal.
// - Test-route bit routes gain stage outputs to the test outputs.
// - Termination field enables one feedback resistor per bit; zero is high-Z.
// - Preset termination is decoded against the global preamp gain field, also when per-channel gain is on.
// - Reduced-current select sets low-power mode when medium-power is clear.
// - Per-channel enable takes each channel gain from its own field.
// - Global preamp gain applies to all channels when per-channel is off.
//
// Chosen here: the APB slave port.
`default_nettype none

module vcb_config_bank #(
    parameter CHANNELS = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Power mode controls
    output reg mediumPowerMode,
    output reg lowPowerMode,
    output reg lowNoiseMode,
    output reg preampPowerdown,
    output reg attenGainstagePowerdown,
    output reg chainPartialSleep,
    output reg chainFullSleep,
    // Gain and termination controls
    output reg [2*CHANNELS-1:0] chanPreampGain,
    output reg [4:0] terminationFeedbackSelect,
    // Offset loop and attenuator controls
    output reg [1:0] preampOffsetLoopCorner,
    output reg [6:0] digitalAttenSwitches,
    output reg analogAttenControl,
    // Test buffer controls
    output reg testBufferPowered,
    output reg gainstageTestRoute,
    output reg [4:0] testBufferFeedbackSelect
);
`include "vcb_consts.vh"

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    reg rstnMeta_q;
    reg rstnSync_q;

    // Assert asynchronously, release after two clean edges.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta_q <= 1'b0;
            rstnSync_q <= 1'b0;
        end else begin
            rstnMeta_q <= 1'b1;
            rstnSync_q <= rstnMeta_q;
        end
    end

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    reg [15:0] termReg_q;
    reg [15:0] powerReg_q;
    reg [15:0] tbufReg_q;
    reg [15:0] chanGainReg_q;
    reg [15:0] attenReg_q;

    // Returns a one-hot select for the five registers, zero when unmapped.
    function [4:0] regSelect;
        input [11:0] addr;
        begin
            case (addr)
                `VCB_ADDR_TERM: regSelect = 5'h01;
                `VCB_ADDR_POWER: regSelect = 5'h02;
                `VCB_ADDR_TBUF: regSelect = 5'h04;
                `VCB_ADDR_CHGAIN: regSelect = 5'h08;
                `VCB_ADDR_ATTEN: regSelect = 5'h10;
                default: regSelect = 5'h00;
            endcase
        end
    endfunction

    wire [4:0] sel;
    wire setupPhase;
    wire doWrite;
    reg [15:0] readMux;

    assign sel = regSelect(paddr);
    assign setupPhase = psel & ~penable;
    // A write lands only at the edge that completes the access phase.
    assign doWrite = psel & penable & pready & pwrite & (sel != 5'h00);

    // Read data selection; unmapped reads return zero.
    always @* begin
        case (sel)
            5'h01: readMux = termReg_q;
            5'h02: readMux = powerReg_q;
            5'h04: readMux = tbufReg_q;
            5'h08: readMux = chanGainReg_q;
            5'h10: readMux = attenReg_q;
            default: readMux = 16'h0000;
        endcase
    end

    // ****************************************************************
    // APB response: one wait-free access phase after every setup
    // ****************************************************************
    always @(posedge ref_clk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & (sel == 5'h00);
            if (setupPhase && !pwrite) begin
                prdata <= {16'h0000, readMux};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // All fields reset to zero; every bit is stored as written.
    always @(posedge ref_clk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
            termReg_q <= `VCB_RST_REG;
            powerReg_q <= `VCB_RST_REG;
            tbufReg_q <= `VCB_RST_REG;
            chanGainReg_q <= `VCB_RST_REG;
            attenReg_q <= `VCB_RST_REG;
        end else if (doWrite) begin
            if (sel[0]) begin
                termReg_q <= pwdata[15:0];
            end
            if (sel[1]) begin
                powerReg_q <= pwdata[15:0];
            end
            if (sel[2]) begin
                tbufReg_q <= pwdata[15:0];
            end
            if (sel[3]) begin
                chanGainReg_q <= pwdata[15:0];
            end
            if (sel[4]) begin
                attenReg_q <= pwdata[15:0];
            end
        end
    end

    // ****************************************************************
    // Decoders
    // ****************************************************************
    wire medMode;
    wire lowMode;
    wire noiseMode;
    wire preOff;
    wire attOff;
    wire partSleep;
    wire fullSleep;
    wire [2*CHANNELS-1:0] gainDec;
    wire [4:0] termDec;

    vcb_power_decode uPower (
        .powerReg(powerReg_q),
        .mediumPowerMode(medMode),
        .lowPowerMode(lowMode),
        .lowNoiseMode(noiseMode),
        .preampOff(preOff),
        .attenGainstageOff(attOff),
        .partialSleep(partSleep),
        .fullSleep(fullSleep)
    );

    vcb_term_decode #(
        .CHANNELS(CHANNELS)
    ) uTerm (
        .termReg(termReg_q),
        .chanGainReg(chanGainReg_q),
        .chanPreampGain(gainDec),
        .terminationFeedback(termDec)
    );

    // Turns a step count into that many shunt switches, lowest first.
    function [6:0] thermometer;
        input [2:0] n;
        integer i;
        begin
            thermometer = 7'h00;
            for (i = 0; i < 7; i = i + 1) begin
                if (i < n) begin
                    thermometer[i] = 1'b1;
                end
            end
        end
    endfunction

    wire digAttEn;
    wire testRoute;

    assign digAttEn = attenReg_q[`VCB_ATT_DIG_EN];
    assign testRoute = attenReg_q[`VCB_ATT_TEST_ROUTE];

    // ****************************************************************
    // Registered control outputs
    // ****************************************************************
    always @(posedge ref_clk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
            mediumPowerMode <= 1'b0;
            lowPowerMode <= 1'b0;
            lowNoiseMode <= 1'b1;
            preampPowerdown <= 1'b0;
            attenGainstagePowerdown <= 1'b0;
            chainPartialSleep <= 1'b0;
            chainFullSleep <= 1'b0;
            chanPreampGain <= {(2*CHANNELS){1'b0}};
            terminationFeedbackSelect <= 5'h00;
            preampOffsetLoopCorner <= 2'h0;
            digitalAttenSwitches <= 7'h00;
            analogAttenControl <= 1'b1;
            testBufferPowered <= 1'b0;
            gainstageTestRoute <= 1'b0;
            testBufferFeedbackSelect <= 5'h00;
        end else begin
            mediumPowerMode <= medMode;
            lowPowerMode <= lowMode;
            lowNoiseMode <= noiseMode;
            preampPowerdown <= preOff;
            attenGainstagePowerdown <= attOff;
            chainPartialSleep <= partSleep;
            chainFullSleep <= fullSleep;
            chanPreampGain <= gainDec;
            terminationFeedbackSelect <= termDec;
            // Corner code passes straight to the offset loop.
            preampOffsetLoopCorner <=
                attenReg_q[`VCB_ATT_CORNER_MSB:`VCB_ATT_CORNER_LSB];
            // Shunt switches follow the step field only in digital mode.
            digitalAttenSwitches <= digAttEn ?
                thermometer(attenReg_q[`VCB_ATT_STEPS_MSB:`VCB_ATT_STEPS_LSB]) :
                7'h00;
            analogAttenControl <= ~digAttEn;
            testBufferPowered <= attenReg_q[`VCB_ATT_TBUF_PWR];
            gainstageTestRoute <= testRoute;
            // Feedback resistors only act while the gain stage is on the test outputs.
            testBufferFeedbackSelect <= testRoute ?
                tbufReg_q[`VCB_TBUF_FB_MSB:`VCB_TBUF_FB_LSB] : 5'h00;
        end
    end

endmodule // vcb_config_bank
`default_nettype wire

//--- vcb_config_props.sv
// Concurrent checks on the ports of the receive-chain configuration bank.
`default_nettype none
`include "vcb_consts.vh"

// ****************************************************************
// Checker module
// ****************************************************************
module vcb_config_props #(
    parameter CHANNELS = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Power mode controls
    input wire logic mediumPowerMode,
    input wire logic lowPowerMode,
    input wire logic lowNoiseMode,
    input wire logic preampPowerdown,
    input wire logic attenGainstagePowerdown,
    input wire logic chainPartialSleep,
    input wire logic chainFullSleep,
    // Gain, termination, attenuator and test buffer controls
    input wire logic [2*CHANNELS-1:0] chanPreampGain,
    input wire logic [4:0] terminationFeedbackSelect,
    input wire logic [1:0] preampOffsetLoopCorner,
    input wire logic [6:0] digitalAttenSwitches,
    input wire logic analogAttenControl,
    input wire logic testBufferPowered,
    input wire logic gainstageTestRoute,
    input wire logic [4:0] testBufferFeedbackSelect
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Write strobes of the two registers whose fields are traced in time.
    wire logic wrAtten = psel && penable && pready && pwrite && paddr == `VCB_ADDR_ATTEN;
    wire logic wrPower = psel && penable && pready && pwrite && paddr == `VCB_ADDR_POWER;

    ready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a single pulse after setup");
    unmapped_err_a: assert property (psel && !penable && !(paddr inside {`VCB_ADDR_TERM,
        `VCB_ADDR_POWER, `VCB_ADDR_TBUF, `VCB_ADDR_CHGAIN, `VCB_ADDR_ATTEN}) |=> pslverr)
        else $error("unmapped access without slave error");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    mode_excl_a: assert property (!(mediumPowerMode && lowPowerMode))
        else $error("low and medium power both active");
    low_noise_a: assert property (lowNoiseMode == !(mediumPowerMode || lowPowerMode))
        else $error("low-noise mode does not follow the power modes");
    full_over_a: assert property (chainFullSleep |-> !chainPartialSleep
        && preampPowerdown && attenGainstagePowerdown)
        else $error("full sleep not overriding");
    partial_pdn_a: assert property (chainPartialSleep |-> preampPowerdown
        && attenGainstagePowerdown)
        else $error("partial sleep leaves a stage running");
    sleep_write_a: assert property (wrPower |-> ##2 chainFullSleep == $past(pwdata[15], 2))
        else $error("full sleep does not follow its bit");
    corner_write_a: assert property (wrAtten |-> ##2
        preampOffsetLoopCorner == $past(pwdata[3:2], 2))
        else $error("offset loop corner does not follow its field");
    buf_power_a: assert property (wrAtten |-> ##2 testBufferPowered == $past(pwdata[8], 2))
        else $error("test buffer power does not follow its bit");
    atten_therm_a: assert property (((digitalAttenSwitches + 7'h01)
        & digitalAttenSwitches) == 7'h00)
        else $error("attenuator switches not a thermometer code");
    analog_off_a: assert property (analogAttenControl |-> digitalAttenSwitches == 7'h00)
        else $error("switches on while analog control selected");
    route_gate_a: assert property (!gainstageTestRoute |->
        testBufferFeedbackSelect == 5'h00)
        else $error("buffer feedback active outside test mode");
endmodule // vcb_config_props

bind vcb_config_bank vcb_config_props #(.CHANNELS(CHANNELS)) u_props (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mediumPowerMode(mediumPowerMode), .lowPowerMode(lowPowerMode),
    .lowNoiseMode(lowNoiseMode), .preampPowerdown(preampPowerdown),
    .attenGainstagePowerdown(attenGainstagePowerdown), .chainPartialSleep(chainPartialSleep),
    .chainFullSleep(chainFullSleep), .chanPreampGain(chanPreampGain),
    .terminationFeedbackSelect(terminationFeedbackSelect),
    .preampOffsetLoopCorner(preampOffsetLoopCorner),
    .digitalAttenSwitches(digitalAttenSwitches), .analogAttenControl(analogAttenControl),
    .testBufferPowered(testBufferPowered), .gainstageTestRoute(gainstageTestRoute),
    .testBufferFeedbackSelect(testBufferFeedbackSelect));
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench of the receive-chain configuration register bank.
`default_nettype none
`include "vcb_consts.vh"

// ****************************************************************
// Testbench top
// ****************************************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] ADR [5] = '{`VCB_ADDR_TERM, `VCB_ADDR_POWER, `VCB_ADDR_TBUF,
        `VCB_ADDR_CHGAIN, `VCB_ADDR_ATTEN};
    // Preset resistor maps by global gain code; code 3 behaves as 18 dB.
    localparam logic [4:0] TMAP [4][4] = '{
        '{`VCB_MAP18_50, `VCB_MAP18_100, `VCB_MAP18_200, `VCB_MAP18_400},
        '{`VCB_MAP24_50, `VCB_MAP24_100, `VCB_MAP24_200, `VCB_MAP24_400},
        '{`VCB_MAP12_50, `VCB_MAP12_100, `VCB_MAP12_200, `VCB_MAP12_400},
        '{`VCB_MAP18_50, `VCB_MAP18_100, `VCB_MAP18_200, `VCB_MAP18_400}};

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, medP, lowP, lnP, preP, attP, partS, fullS, anaC, tbP, tRoute;
    logic [15:0] chGain;
    logic [4:0] termFb, tbFb;
    logic [1:0] corner;
    logic [6:0] attSw;
    logic [15:0] mdl [5];
    logic [31:0] rd;
    logic err;
    logic [15:0] cg;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    vcb_config_bank #(.CHANNELS(8)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mediumPowerMode(medP), .lowPowerMode(lowP), .lowNoiseMode(lnP),
        .preampPowerdown(preP), .attenGainstagePowerdown(attP), .chainPartialSleep(partS),
        .chainFullSleep(fullS), .chanPreampGain(chGain), .terminationFeedbackSelect(termFb),
        .preampOffsetLoopCorner(corner), .digitalAttenSwitches(attSw),
        .analogAttenControl(anaC), .testBufferPowered(tbP), .gainstageTestRoute(tRoute),
        .testBufferFeedbackSelect(tbFb));

    // Free-running 25 MHz clock.
    always #20 ref_clk = ~ref_clk;

    // Cycle ceiling that cuts a hang short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            final_report();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer: setup, then access until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int w;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge ref_clk);
            w++;
        end while (pready !== 1'b1);
        chk("latency", w, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Works out every control output from the model registers and compares.
    task automatic check_all();
        logic [15:0] t, p, b, c, a;
        logic [4:0] term;
        t = mdl[0];
        p = mdl[1];
        b = mdl[2];
        c = mdl[3];
        a = mdl[4];
        term = !t[8] ? 5'h00 : t[5] ? t[4:0] : TMAP[t[14:13]][t[7:6]];
        chk("power", {medP, lowP, lnP}, {p[11] & ~p[10], p[10] & ~p[11], ~(p[11] ^ p[10])});
        chk("sleep", {fullS, partS}, {p[15], p[14] & ~p[15]});
        chk("pdn", {preP, attP}, {|p[15:13], p[15] | p[14] | p[12]});
        chk("gain", chGain, t[15] ? c : {8{t[14:13]}});
        chk("term", termFb, term);
        chk("corner", corner, a[3:2]);
        chk("atten", {anaC, attSw}, {~a[7], a[7] ? 7'((1 << a[6:4]) - 1) : 7'h00});
        chk("tbuf", {tbP, tRoute}, {a[8], a[9]});
        chk("tbfb", tbFb, a[9] ? b[4:0] : 5'h00);
    endtask

    // Writes a register, checks the outputs one edge later, then reads it back.
    task automatic wr_chk(input int i, input logic [31:0] d);
        apb(1'b1, ADR[i], d);
        chk("wr_err", err, 1'b0);
        mdl[i] = d[15:0];
        @(posedge ref_clk);
        #1;
        check_all();
        apb(1'b0, ADR[i], 32'h0000_0000);
        chk("rdback", rd, {16'h0000, mdl[i]});
    endtask

    // Reads every register and compares with the model.
    task automatic check_regs();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ADR[i], 32'h0000_0000);
            chk("reg", rd, {16'h0000, mdl[i]});
        end
        #1;
        check_all();
    endtask

    // Holds reset for 16 cycles and clears the model.
    task automatic do_reset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 5; i++) mdl[i] = 16'h0000;
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'h6e20dba3));
        do_reset();
        check_regs();
        for (int i = 0; i < 64; i++) wr_chk(1, {i[5:0], 10'h000});
        for (int i = 0; i < 64; i++) begin
            wr_chk(0, {1'b0, i[1:0], 4'h0, i[2], i[4:3], i[5], 5'($urandom)});
        end
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 8; k++) cg[2*k +: 2] = 2'($urandom_range(2));
            wr_chk(0, {i[0], i[2:1], 4'h0, i[3], 8'h00});
            wr_chk(3, {16'h0000, cg});
        end
        for (int i = 0; i < 256; i++) begin
            wr_chk(2, {27'h0, 5'($urandom)});
            wr_chk(4, {22'h0, i[7:5], i[4:2], i[1:0], 2'h0});
        end
        wr_chk(1, 32'hffff_ffff);
        foreach (ADR[i]) begin
            apb(1'b1, ADR[i] + 12'h100, 32'hffff_ffff);
            chk("bad_wr", {err, 16'h0000}, {1'b1, 16'h0000});
            apb(1'b0, ADR[i] - 12'h030, 32'h0000_0000);
            chk("bad_rd", {err, rd}, {1'b1, 32'h0000_0000});
        end
        check_regs();
        repeat (100) wr_chk($urandom_range(1) ? 4 : 2, $urandom);
        do_reset();
        check_regs();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
